// >>> hdl/trig_pkg.sv
// constants and types of the debug trigger unit
package trig_pkg;
  localparam int TRIGGER_COUNT = 4;
  localparam int IDX_W = 2;
  localparam logic [31:0] TRIGGER_COUNT_W = 32'h0000_0004;
  localparam logic [11:0] ADDR_SELECT = 12'h7a0;
  localparam logic [11:0] ADDR_DATA_ONE = 12'h7a1;
  localparam logic [11:0] ADDR_COMPARE = 12'h7a2;
  localparam logic [11:0] ADDR_DATA_THREE = 12'h7a3;
  localparam logic [11:0] ADDR_TYPE_INFO = 12'h7a4;
  localparam logic [3:0] TYPE_ADDR = 4'h6;
  localparam logic [3:0] TYPE_EXC = 4'h5;
  localparam int TYPE_MSB = 31;
  localparam int TYPE_LSB = 28;
  localparam int DMODE_BIT = 27;
  localparam int MATCH_MSB = 10;
  localparam int MATCH_LSB = 7;
  localparam int EXE_BIT = 2;
  localparam int STORE_BIT = 1;
  localparam int LOAD_BIT = 0;
  localparam int NMI_BIT = 10;
  localparam logic [3:0] ACTION_ADDR = 4'h1;
  localparam logic [5:0] ACTION_EXC = 6'h01;
  localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
  localparam logic [31:0] COMPARE_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_CTRL_RESET = 32'h6800_1044;
  localparam logic [31:0] EXC_CTRL_RESET = 32'h5800_0201;
  localparam logic [31:0] TINFO_SUPPORTED = 32'h0000_0060;
  localparam logic [31:0] TINFO_ABSENT = 32'h0000_0001;
  typedef enum logic [3:0] {
    MATCH_EQ = 4'h0,
    MATCH_GE = 4'h2,
    MATCH_LT = 4'h3
  } match_mode_type;
endpackage

// >>> hdl/trig_if.sv
// settings of one trigger and its hit, between unit and comparator
`timescale 1ns/10ps
interface trig_if;
  import trig_pkg::*;
  logic type_exc;
  match_mode_type match_mode;
  logic en_exe;
  logic en_store;
  logic en_load;
  logic nmi_en;
  logic [31:0] compare;
  logic hit;
  modport cfg (output type_exc, match_mode, en_exe, en_store, en_load, nmi_en, compare,
    input hit);
  modport cmp (input type_exc, match_mode, en_exe, en_store, en_load, nmi_en, compare,
    output hit);
endinterface

// >>> hdl/trig_compare.sv
// comparator of one trigger against core events
`timescale 1ns/10ps
module trig_compare (
  trig_if.cmp t,
  input wire logic active,
  input wire logic exec_valid,
  input wire logic [31:0] exec_addr,
  input wire logic store_valid,
  input wire logic [31:0] store_addr,
  input wire logic load_valid,
  input wire logic [31:0] load_addr,
  input wire logic exc_valid,
  input wire logic [4:0] exc_code,
  input wire logic nmi_valid
);
  import trig_pkg::*;

  function automatic logic addr_match(input logic [31:0] a, input logic [31:0] c,
    input match_mode_type m);
    case (m)
      MATCH_GE: return a >= c;
      MATCH_LT: return a < c;
      default: return a == c;
    endcase
  endfunction

  logic addr_hit;
  logic exc_hit;

  always_comb begin
    addr_hit = (exec_valid & t.en_exe & addr_match(exec_addr, t.compare, t.match_mode))
      | (store_valid & t.en_store & addr_match(store_addr, t.compare, t.match_mode))
      | (load_valid & t.en_load & addr_match(load_addr, t.compare, t.match_mode));
    exc_hit = (exc_valid & t.compare[exc_code]) | (nmi_valid & t.nmi_en);
  end

  assign t.hit = active & (t.type_exc ? exc_hit : addr_hit);
endmodule

// >>> hdl/debug_trigger_unit.sv
// debug trigger unit: trigger registers, csr access and debug entry
`timescale 1ns/10ps
// How it works
// - select register picks trigger shown in data registers
// - select above count stores count minus one, count itself kept
// - type field six address match, five exception
// - lower bits laid out by stored type
// - debug only write bit reads one
// - data registers writable only in debug mode
// - match modes equal, greater-equal, less-than only
// - execute, store, load enables match independently
// - address trigger breaks before, action one
// - machine bit one, chain hit lower-privilege zero
// - exception trigger fires on nmi when enabled
// - exception machine bit one, action one
// - second data register holds compare or codes
// - third data register reads zero, ignores writes
// - info field one bit per supported type
// - existing trigger reports types five and six
// - missing trigger reports info value one
module debug_trigger_unit (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic csr_valid,
  input wire logic csr_write,
  input wire logic [11:0] csr_addr,
  input wire logic [31:0] csr_wdata,
  input wire logic debug_mode,
  input wire logic machine_mode,
  input wire logic exec_valid,
  input wire logic [31:0] exec_addr,
  input wire logic store_valid,
  input wire logic [31:0] store_addr,
  input wire logic load_valid,
  input wire logic [31:0] load_addr,
  input wire logic exc_valid,
  input wire logic [4:0] exc_code,
  input wire logic nmi_valid,
  output logic csr_done,
  output logic csr_error,
  output logic [31:0] csr_rdata,
  output logic debug_enter,
  output logic [trig_pkg::TRIGGER_COUNT-1:0] trigger_fired
);
  import trig_pkg::*;

  logic [31:0] trigger_select;
  logic [TRIGGER_COUNT-1:0] type_exc;
  logic [TRIGGER_COUNT-1:0] en_exe;
  logic [TRIGGER_COUNT-1:0] en_store;
  logic [TRIGGER_COUNT-1:0] en_load;
  logic [TRIGGER_COUNT-1:0] nmi_en;
  match_mode_type match_mode [TRIGGER_COUNT];
  logic [TRIGGER_COUNT-1:0][31:0] compare;
  logic [TRIGGER_COUNT-1:0] hit;
  logic [IDX_W-1:0] sel_idx;
  logic sel_exists;
  logic sel_type_exc;
  logic [31:0] sel_compare;
  logic priv_ok;
  logic access_ok;
  logic data_we;
  logic active;
  logic [31:0] data_one;
  logic [31:0] next_rdata;

  assign sel_idx = trigger_select[IDX_W-1:0];
  assign sel_exists = trigger_select < TRIGGER_COUNT_W;
  assign sel_type_exc = type_exc[sel_idx];
  assign sel_compare = compare[sel_idx];
  assign priv_ok = debug_mode | machine_mode;
  assign active = machine_mode & ~debug_mode;

  // access check per register
  always_comb begin
    case (csr_addr)
      ADDR_SELECT: access_ok = priv_ok;
      ADDR_DATA_ONE, ADDR_COMPARE, ADDR_DATA_THREE: access_ok = csr_write ? debug_mode : priv_ok;
      ADDR_TYPE_INFO: access_ok = priv_ok & ~csr_write;
      default: access_ok = 1'b0;
    endcase
  end

  assign data_we = csr_valid & csr_write & access_ok & sel_exists;

  // trigger select register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trigger_select <= SELECT_RESET;
    end else if (csr_valid & csr_write & access_ok & (csr_addr == ADDR_SELECT)) begin
      if (csr_wdata > TRIGGER_COUNT_W) begin
        trigger_select <= TRIGGER_COUNT_W - 32'h0000_0001;
      end else begin
        trigger_select <= csr_wdata;
      end
    end
  end

  // per trigger registers and comparators
  for (genvar i = 0; i < TRIGGER_COUNT; i++) begin : g_trig
    trig_if link ();
    logic we_i;
    assign we_i = data_we & (sel_idx == IDX_W'(i));

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        type_exc[i] <= 1'b0;
        match_mode[i] <= match_mode_type'(ADDR_CTRL_RESET[MATCH_MSB:MATCH_LSB]);
        en_exe[i] <= ADDR_CTRL_RESET[EXE_BIT];
        en_store[i] <= ADDR_CTRL_RESET[STORE_BIT];
        en_load[i] <= ADDR_CTRL_RESET[LOAD_BIT];
        nmi_en[i] <= EXC_CTRL_RESET[NMI_BIT];
      end else if (we_i & (csr_addr == ADDR_DATA_ONE)) begin
        type_exc[i] <= csr_wdata[TYPE_MSB:TYPE_LSB] == TYPE_EXC;
        if (csr_wdata[TYPE_MSB:TYPE_LSB] == TYPE_EXC) begin
          nmi_en[i] <= csr_wdata[NMI_BIT];
        end else begin
          en_exe[i] <= csr_wdata[EXE_BIT];
          en_store[i] <= csr_wdata[STORE_BIT];
          en_load[i] <= csr_wdata[LOAD_BIT];
          if (csr_wdata[MATCH_MSB:MATCH_LSB] == MATCH_EQ ||
              csr_wdata[MATCH_MSB:MATCH_LSB] == MATCH_GE ||
              csr_wdata[MATCH_MSB:MATCH_LSB] == MATCH_LT) begin
            match_mode[i] <= match_mode_type'(csr_wdata[MATCH_MSB:MATCH_LSB]);
          end
        end
      end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        compare[i] <= COMPARE_RESET;
      end else if (we_i & (csr_addr == ADDR_COMPARE)) begin
        compare[i] <= csr_wdata;
      end
    end

    assign link.type_exc = type_exc[i];
    assign link.match_mode = match_mode[i];
    assign link.en_exe = en_exe[i];
    assign link.en_store = en_store[i];
    assign link.en_load = en_load[i];
    assign link.nmi_en = nmi_en[i];
    assign link.compare = compare[i];
    assign hit[i] = link.hit;

    trig_compare u_compare (
      .t(link.cmp),
      .active(active),
      .exec_valid(exec_valid),
      .exec_addr(exec_addr),
      .store_valid(store_valid),
      .store_addr(store_addr),
      .load_valid(load_valid),
      .load_addr(load_addr),
      .exc_valid(exc_valid),
      .exc_code(exc_code),
      .nmi_valid(nmi_valid)
    );
  end

  // first data register view by stored type
  always_comb begin
    if (!sel_exists) begin
      data_one = 32'h0000_0000;
    end else if (sel_type_exc) begin
      data_one = {TYPE_EXC, 1'b1, 16'h0000, nmi_en[sel_idx], 1'b1, 3'h0, ACTION_EXC};
    end else begin
      data_one = {TYPE_ADDR, 1'b1, 6'h00, 1'b0, 4'h0, ACTION_ADDR, 1'b0,
        match_mode[sel_idx], 1'b1, 3'h0, en_exe[sel_idx], en_store[sel_idx],
        en_load[sel_idx]};
    end
  end

  // read mux
  always_comb begin
    case (csr_addr)
      ADDR_SELECT: next_rdata = trigger_select;
      ADDR_DATA_ONE: next_rdata = data_one;
      ADDR_COMPARE: next_rdata = sel_exists ? sel_compare : 32'h0000_0000;
      ADDR_DATA_THREE: next_rdata = 32'h0000_0000;
      ADDR_TYPE_INFO: next_rdata = sel_exists ? TINFO_SUPPORTED : TINFO_ABSENT;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // csr answer one cycle after the request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      csr_done <= 1'b0;
      csr_error <= 1'b0;
      csr_rdata <= 32'h0000_0000;
    end else begin
      csr_done <= csr_valid;
      csr_error <= csr_valid & ~access_ok;
      csr_rdata <= (csr_valid & access_ok & ~csr_write) ? next_rdata : 32'h0000_0000;
    end
  end

  // debug entry request towards the controller
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      debug_enter <= 1'b0;
      trigger_fired <= '0;
    end else begin
      debug_enter <= |hit;
      trigger_fired <= hit;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic rd_one;
  assign rd_one = csr_valid & ~csr_write & priv_ok & (csr_addr == ADDR_DATA_ONE) & sel_exists;

  a_sel_clamp: assert property (
    csr_valid && csr_write && priv_ok && csr_addr == ADDR_SELECT
      && csr_wdata > TRIGGER_COUNT_W
    |=> trigger_select == TRIGGER_COUNT_W - 32'h0000_0001)
    else $error("select not clamped");

  a_sel_store: assert property (
    csr_valid && csr_write && priv_ok && csr_addr == ADDR_SELECT
      && csr_wdata <= TRIGGER_COUNT_W
    |=> trigger_select == $past(csr_wdata))
    else $error("select not stored");

  a_type_view: assert property (
    rd_one |=> csr_done && (csr_rdata[TYPE_MSB:TYPE_LSB] ==
      ($past(sel_type_exc) ? TYPE_EXC : TYPE_ADDR)))
    else $error("type field wrong");

  a_dmode_one: assert property (
    rd_one |=> csr_rdata[DMODE_BIT])
    else $error("dmode bit not one");

  a_addr_fixed: assert property (
    rd_one && !sel_type_exc |=> csr_rdata[15:12] == ACTION_ADDR && csr_rdata[6]
      && csr_rdata[26:16] == 11'h000 && csr_rdata[11] == 1'b0 && csr_rdata[5:3] == 3'h0)
    else $error("address trigger fixed fields wrong");

  a_exc_fixed: assert property (
    rd_one && sel_type_exc |=> csr_rdata[5:0] == ACTION_EXC && csr_rdata[9]
      && csr_rdata[26:11] == 16'h0000)
    else $error("exception trigger fixed fields wrong");

  a_mwrite_block: assert property (
    csr_valid && csr_write && !debug_mode
      && (csr_addr == ADDR_COMPARE || csr_addr == ADDR_DATA_ONE)
    |=> csr_error && $stable(compare) && $stable(type_exc) && $stable(en_exe))
    else $error("machine mode write changed a trigger");

  a_match_legal: assert property (
    match_mode[sel_idx] == MATCH_EQ || match_mode[sel_idx] == MATCH_GE
      || match_mode[sel_idx] == MATCH_LT)
    else $error("illegal match mode stored");

  a_exe_fire: assert property (
    exec_valid && active && !type_exc[0] && en_exe[0] && match_mode[0] == MATCH_EQ
      && exec_addr == compare[0]
    |=> debug_enter && trigger_fired[0])
    else $error("execute match did not fire");

  a_nmi_fire: assert property (
    nmi_valid && active && type_exc[0] && nmi_en[0] |=> debug_enter && trigger_fired[0])
    else $error("nmi trigger did not fire");

  a_quiet_debug: assert property (
    debug_mode |=> !debug_enter)
    else $error("trigger fired in debug mode");

  a_cmp_read: assert property (
    csr_valid && !csr_write && priv_ok && csr_addr == ADDR_COMPARE && sel_exists
    |=> csr_rdata == $past(sel_compare))
    else $error("compare read wrong");

  a_three_zero: assert property (
    csr_valid && csr_addr == ADDR_DATA_THREE |=> csr_rdata == 32'h0000_0000)
    else $error("third data register not zero");

  a_info_value: assert property (
    csr_valid && !csr_write && priv_ok && csr_addr == ADDR_TYPE_INFO
    |=> csr_rdata == ($past(sel_exists) ? TINFO_SUPPORTED : TINFO_ABSENT))
    else $error("info value wrong");

  a_store_fire: assert property (
    store_valid && active && !type_exc[2] && en_store[2] && match_mode[2] == MATCH_GE
      && store_addr >= compare[2]
    |=> debug_enter && trigger_fired[2])
    else $error("store match did not fire");

  a_load_fire: assert property (
    load_valid && active && !type_exc[3] && en_load[3] && match_mode[3] == MATCH_LT
      && load_addr < compare[3]
    |=> debug_enter && trigger_fired[3])
    else $error("load match did not fire");

  a_exc_fire: assert property (
    exc_valid && active && type_exc[1] && compare[1][exc_code] |=> trigger_fired[1])
    else $error("exception code trigger did not fire");

  a_inactive_quiet: assert property (
    !machine_mode |=> trigger_fired == '0)
    else $error("trigger fired outside machine mode");

  a_read_allowed: assert property (
    csr_valid && !csr_write && machine_mode
      && (csr_addr == ADDR_DATA_ONE || csr_addr == ADDR_COMPARE
      || csr_addr == ADDR_DATA_THREE || csr_addr == ADDR_TYPE_INFO)
    |=> csr_done && !csr_error)
    else $error("machine mode read refused");

  a_type_store: assert property (
    csr_valid && csr_write && debug_mode && csr_addr == ADDR_DATA_ONE && sel_exists
    |=> sel_type_exc == ($past(csr_wdata[TYPE_MSB:TYPE_LSB]) == TYPE_EXC))
    else $error("trigger type not stored");

  a_absent_zero: assert property (
    csr_valid && !csr_write && priv_ok && csr_addr == ADDR_DATA_ONE && !sel_exists
    |=> csr_rdata == 32'h0000_0000)
    else $error("missing trigger data not zero");

  a_write_rdata: assert property (
    csr_valid && csr_write |=> csr_done && csr_rdata == 32'h0000_0000)
    else $error("write returned read data");

  c_exe_fire: cover property (exec_valid && active && hit[0] ##1 debug_enter);
  c_load_fire: cover property (load_valid && active && hit[3] ##1 debug_enter);
  c_nmi_fire: cover property (nmi_valid && active && |(type_exc & nmi_en) ##1 debug_enter);
  c_sel_clamp: cover property (csr_valid && csr_write && csr_addr == ADDR_SELECT
    && csr_wdata > TRIGGER_COUNT_W);
  c_mwrite: cover property (csr_valid && csr_write && machine_mode && !debug_mode
    && csr_addr == ADDR_COMPARE);
endmodule

// >>> verification/core_model.sv
// behavioural debug controller of the core facing the trigger unit
`timescale 1ns/10ps
module core_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic debug_enter,
  input wire logic halt_req,
  input wire logic resume_req,
  output logic debug_mode
);
  // enter debug mode on a trigger hit or a halt, leave on resume or reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      debug_mode <= 1'b0;
    end else if (debug_enter || halt_req) begin
      debug_mode <= 1'b1;
    end else if (resume_req) begin
      debug_mode <= 1'b0;
    end
  end
endmodule

// >>> verification/testbench.sv
// self-checking bench of the debug trigger unit
`timescale 1ns/10ps
module testbench;
  import trig_pkg::*;
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic dbg;
    logic err;
    logic [31:0] rdata;
  } row_type;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic csr_valid = 1'b0;
  logic csr_write = 1'b0;
  logic [11:0] csr_addr = 12'h000;
  logic [31:0] csr_wdata = 32'h0;
  logic machine_mode = 1'b1;
  logic exec_valid = 1'b0;
  logic [31:0] exec_addr = 32'h0;
  logic store_valid = 1'b0;
  logic [31:0] store_addr = 32'h0;
  logic load_valid = 1'b0;
  logic [31:0] load_addr = 32'h0;
  logic exc_valid = 1'b0;
  logic [4:0] exc_code = 5'h00;
  logic nmi_valid = 1'b0;
  logic halt_req = 1'b0;
  logic resume_req = 1'b0;
  logic debug_mode;
  logic csr_done;
  logic csr_error;
  logic [31:0] csr_rdata;
  logic debug_enter;
  logic [TRIGGER_COUNT-1:0] trigger_fired;
  logic err;
  logic [31:0] rd;
  int mismatches = 0;
  int checked = 0;
  row_type rows [0:32] = '{
    '{1'b0, 12'h7a0, 32'h0, 1'b0, 1'b0, 32'h0},
    '{1'b0, 12'h7a1, 32'h0, 1'b0, 1'b0, 32'h6800_1044},
    '{1'b0, 12'h7a2, 32'h0, 1'b0, 1'b0, 32'h0},
    '{1'b0, 12'h7a3, 32'h0, 1'b0, 1'b0, 32'h0},
    '{1'b0, 12'h7a4, 32'h0, 1'b0, 1'b0, 32'h60},
    '{1'b1, 12'h7a2, 32'h100, 1'b0, 1'b1, 32'h0},
    '{1'b0, 12'h7a2, 32'h0, 1'b0, 1'b0, 32'h0},
    '{1'b1, 12'h7a2, 32'h100, 1'b1, 1'b0, 32'h0},
    '{1'b0, 12'h7a2, 32'h0, 1'b1, 1'b0, 32'h100},
    '{1'b1, 12'h7a3, 32'hffff_ffff, 1'b1, 1'b0, 32'h0},
    '{1'b0, 12'h7a3, 32'h0, 1'b1, 1'b0, 32'h0},
    '{1'b1, 12'h7a4, 32'h0, 1'b1, 1'b1, 32'h0},
    '{1'b0, 12'h7a5, 32'h0, 1'b0, 1'b1, 32'h0},
    '{1'b1, 12'h7a0, 32'h7, 1'b0, 1'b0, 32'h0},
    '{1'b0, 12'h7a0, 32'h0, 1'b0, 1'b0, 32'h3},
    '{1'b1, 12'h7a0, 32'h4, 1'b0, 1'b0, 32'h0},
    '{1'b0, 12'h7a0, 32'h0, 1'b0, 1'b0, 32'h4},
    '{1'b0, 12'h7a4, 32'h0, 1'b0, 1'b0, 32'h1},
    '{1'b0, 12'h7a1, 32'h0, 1'b0, 1'b0, 32'h0},
    '{1'b1, 12'h7a0, 32'h1, 1'b0, 1'b0, 32'h0},
    '{1'b1, 12'h7a1, 32'h5800_0401, 1'b1, 1'b0, 32'h0},
    '{1'b0, 12'h7a1, 32'h0, 1'b0, 1'b0, 32'h5800_0601},
    '{1'b1, 12'h7a2, 32'h4, 1'b1, 1'b0, 32'h0},
    '{1'b1, 12'h7a0, 32'h2, 1'b0, 1'b0, 32'h0},
    '{1'b1, 12'h7a2, 32'h1000, 1'b1, 1'b0, 32'h0},
    '{1'b1, 12'h7a1, 32'h6800_1102, 1'b1, 1'b0, 32'h0},
    '{1'b1, 12'h7a1, 32'h6800_1082, 1'b1, 1'b0, 32'h0},
    '{1'b0, 12'h7a1, 32'h0, 1'b0, 1'b0, 32'h6800_1142},
    '{1'b1, 12'h7a0, 32'h3, 1'b0, 1'b0, 32'h0},
    '{1'b1, 12'h7a2, 32'h200, 1'b1, 1'b0, 32'h0},
    '{1'b1, 12'h7a1, 32'h6800_1181, 1'b1, 1'b0, 32'h0},
    '{1'b0, 12'h7a1, 32'h0, 1'b0, 1'b0, 32'h6800_11c1},
    '{1'b0, 12'h7a4, 32'h0, 1'b0, 1'b0, 32'h60}
  };

  always #2.5 ref_clk = ~ref_clk;

  debug_trigger_unit u_dut (
    .ref_clk(ref_clk), .rst(rst), .csr_valid(csr_valid), .csr_write(csr_write),
    .csr_addr(csr_addr), .csr_wdata(csr_wdata), .debug_mode(debug_mode),
    .machine_mode(machine_mode), .exec_valid(exec_valid), .exec_addr(exec_addr),
    .store_valid(store_valid), .store_addr(store_addr), .load_valid(load_valid),
    .load_addr(load_addr), .exc_valid(exc_valid), .exc_code(exc_code),
    .nmi_valid(nmi_valid), .csr_done(csr_done), .csr_error(csr_error),
    .csr_rdata(csr_rdata), .debug_enter(debug_enter), .trigger_fired(trigger_fired)
  );

  core_model u_core (
    .ref_clk(ref_clk), .rst(rst), .debug_enter(debug_enter), .halt_req(halt_req),
    .resume_req(resume_req), .debug_mode(debug_mode)
  );

  task automatic print_verdict;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic set_debug(input logic v);
    @(negedge ref_clk);
    halt_req <= v;
    resume_req <= !v;
    @(negedge ref_clk);
    halt_req <= 1'b0;
    resume_req <= 1'b0;
  endtask

  // one csr access, answer awaited under a bounded count
  task automatic csr(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic e, output logic [31:0] r);
    int n;
    n = 0;
    @(negedge ref_clk);
    csr_valid <= 1'b1;
    csr_write <= wr;
    csr_addr <= a;
    csr_wdata <= d;
    @(negedge ref_clk);
    csr_valid <= 1'b0;
    while (csr_done !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    if (csr_done !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
    e = csr_error;
    r = csr_rdata;
  endtask

  // one core event: 0 execute, 1 store, 2 load, 3 exception, 4 nmi
  task automatic ev(input int kind, input logic [31:0] v, input logic [3:0] exp);
    @(negedge ref_clk);
    exec_valid <= (kind == 0);
    store_valid <= (kind == 1);
    load_valid <= (kind == 2);
    exc_valid <= (kind == 3);
    nmi_valid <= (kind == 4);
    exec_addr <= v;
    store_addr <= v;
    load_addr <= v;
    exc_code <= v[4:0];
    @(negedge ref_clk);
    {exec_valid, store_valid, load_valid, exc_valid, nmi_valid} <= 5'h00;
    check_val("trigger_fired", {28'h0, exp}, {28'h0, trigger_fired});
    check_val("debug_enter", {31'h0, |exp}, {31'h0, debug_enter});
    set_debug(1'b0);
  endtask

  initial begin
    repeat (5) @(negedge ref_clk);
    check_val("csr_done", 32'h0, {31'h0, csr_done});
    rst <= 1'b0;
    foreach (rows[i]) begin
      set_debug(rows[i].dbg);
      csr(rows[i].wr, rows[i].addr, rows[i].wdata, err, rd);
      check_val("csr_error", {31'h0, rows[i].err}, {31'h0, err});
      check_val("csr_rdata", rows[i].rdata, rd);
    end
    set_debug(1'b0);
    ev(0, 32'h100, 4'h1);
    ev(0, 32'h104, 4'h0);
    ev(1, 32'h1000, 4'h4);
    ev(1, 32'hfff, 4'h0);
    ev(2, 32'h1ff, 4'h8);
    ev(2, 32'h200, 4'h0);
    ev(3, 32'h2, 4'h2);
    ev(3, 32'h3, 4'h0);
    ev(4, 32'h0, 4'h2);
    set_debug(1'b1);
    ev(0, 32'h100, 4'h0);
    machine_mode <= 1'b0;
    ev(0, 32'h100, 4'h0);
    machine_mode <= 1'b1;
    @(negedge ref_clk);
    rst <= 1'b1;
    @(negedge ref_clk);
    check_val("debug_enter", 32'h0, {31'h0, debug_enter});
    rst <= 1'b0;
    csr(1'b0, 12'h7a0, 32'h0, err, rd);
    check_val("csr_rdata", 32'h0, rd);
    csr(1'b0, 12'h7a1, 32'h0, err, rd);
    check_val("csr_rdata", 32'h6800_1044, rd);
    print_verdict();
  end
endmodule
